/* fcg_defines.svh */
`ifndef FCG_DEFINES_SVH
`define FCG_DEFINES_SVH

`define FCG_OFF_CONFIG 8'h04
`define FCG_OFF_GEOMETRY 8'h08
`define FCG_CONFIG_RESET 32'h0000_0000
`define FCG_CONFIG_WMASK 32'h0007_039E
`define FCG_BIT_CACHE_OFF 18
`define FCG_POLICY_HI 17
`define FCG_POLICY_LO 16
`define FCG_SLEEP_HI 9
`define FCG_SLEEP_LO 8
`define FCG_BIT_MANUAL 7
`define FCG_WAIT_HI 4
`define FCG_WAIT_LO 1
`define FCG_PSZ_HI 18
`define FCG_PSZ_LO 16
`define FCG_PAGE_SIZE_CODE 3'h6
`define FCG_PAGE_COUNT 16'h0100
`define FCG_WAIT_RESET 4'h0
`define FCG_RP_ZERO 2'h0
`define FCG_RP_LOWPWR 2'h1
`define FCG_RP_DETERM 2'h2
`define FCG_SP_FIRST_TOUCH 2'h0
`define FCG_SP_WITH_CORE 2'h1
`define FCG_SP_OFF 2'h3

`endif

/* fcg_pkg.sv */
package fcg_pkg;
  typedef enum logic [2:0] {
    FCG_IDLE = 3'b001,
    FCG_WAIT = 3'b010,
    FCG_DONE = 3'b100
  } fcg_rd_state_t;
endpackage

/* fcg_rd_if.sv */
`timescale 1ns/10ps
interface fcg_rd_if;
  logic req;
  logic hit;
  logic [3:0] stall;
  logic ready;
  modport ctl (input req, input hit, input stall, output ready);
  modport top (output req, output hit, output stall, input ready);
endinterface

/* fcg_read_timer.sv */
`timescale 1ns/10ps
module fcg_read_timer
  import fcg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Read timing
  fcg_rd_if.ctl rd
);
  typedef struct packed {
    fcg_rd_state_t st;
    logic [3:0] cnt;
  } fcg_tmr_t;

  fcg_tmr_t cur;
  fcg_tmr_t next_cur;

  always_comb begin
    next_cur = cur;
    rd.ready = 1'b0;
    unique case (cur.st)
      FCG_IDLE: begin
        if (rd.req) begin
          if (rd.stall == 4'h0) begin
            rd.ready = 1'b1;
          end else begin
            next_cur.cnt = rd.stall;
            next_cur.st = FCG_WAIT;
          end
        end
      end
      FCG_WAIT: begin
        next_cur.cnt = cur.cnt - 4'h1;
        if (cur.cnt == 4'h1) begin
          next_cur.st = FCG_DONE;
        end
      end
      FCG_DONE: begin
        // Ready after exactly stall waited cycles
        rd.ready = 1'b1;
        next_cur.st = FCG_IDLE;
      end
      default: begin
        next_cur.st = FCG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '{st: FCG_IDLE, cnt: 4'h0};
    end else begin
      cur <= next_cur;
    end
  end
endmodule

/* fcg_config.sv */
// What this block does
// - Unused configuration bits always read zero
// - Bit 18 turns read cache off
// - Policy 0: no hit wait states
// - Policy 1: one extra wait per miss, none at wait count 15
// - Policy 2: hit equals miss timing
// - Sleep policy 0: wake on access
// - Sleep policy 1: wake with core
// - Sleep policy 3: no auto power cut
// - Auto commit on last buffer word
// - Manual mode needs explicit commit command
// - Reads stall by wait count plus one cycles when nonzero
// - Wait count resets to zero
// - Page size code reported, bits 18:16
// - Page count reported, bits 15:0
// - Power cut flag follows sleep policy
`timescale 1ns/10ps
`include "fcg_defines.svh"
module fcg_config
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic write_protect,
  // Flash read request
  input wire logic rd_req,
  input wire logic rd_hit,
  output logic rd_ready,
  output logic cache_active,
  // Page buffer
  input wire logic buf_last_word_wr,
  input wire logic commit_cmd,
  output logic page_commit,
  // Sleep and power
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic flash_access,
  output logic power_cut_status
);
  import fcg_pkg::*;

  typedef struct packed {
    logic [31:0] config_q;
    logic power_cut;
    logic commit;
    logic [31:0] rdata;
  } fcg_state_t;

  fcg_state_t cur;
  fcg_state_t next_cur;
  fcg_rd_if rdi ();

  function automatic logic [31:0] fcg_read(input logic [7:0] a, input logic [31:0] c);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `FCG_OFF_CONFIG) begin
      v = c & `FCG_CONFIG_WMASK;
    end else if (a == `FCG_OFF_GEOMETRY) begin
      v[`FCG_PSZ_HI:`FCG_PSZ_LO] = `FCG_PAGE_SIZE_CODE;
      v[15:0] = `FCG_PAGE_COUNT;
    end
    return v;
  endfunction

  logic [1:0] read_policy;
  logic [1:0] sleep_power_policy;
  logic [3:0] read_wait_count;
  logic cache_off;
  logic manual_page_commit;
  logic [3:0] stall;

  assign cache_off = cur.config_q[`FCG_BIT_CACHE_OFF];
  assign read_policy = cur.config_q[`FCG_POLICY_HI:`FCG_POLICY_LO];
  assign sleep_power_policy = cur.config_q[`FCG_SLEEP_HI:`FCG_SLEEP_LO];
  assign manual_page_commit = cur.config_q[`FCG_BIT_MANUAL];
  assign read_wait_count = cur.config_q[`FCG_WAIT_HI:`FCG_WAIT_LO];

  // Stall selection; with cache off every read counts as a miss
  always_comb begin
    stall = read_wait_count;
    if (!cache_off && rd_hit) begin
      stall = 4'h0;
      if (read_policy == `FCG_RP_DETERM) begin
        stall = read_wait_count;
      end
    end else if (read_policy == `FCG_RP_LOWPWR) begin
      // Saturate so fifteen waits plus penalty cannot wrap
      stall = (read_wait_count == 4'hF) ? 4'hF : read_wait_count + 4'h1;
    end
  end

  assign rdi.req = rd_req;
  assign rdi.hit = rd_hit;
  assign rdi.stall = stall;
  assign rd_ready = rdi.ready;
  assign cache_active = !cache_off;

  fcg_read_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .rd(rdi)
  );

  always_comb begin
    next_cur = cur;
    next_cur.commit = 1'b0;
    next_cur.rdata = reg_rd ? fcg_read(reg_addr, cur.config_q) : 32'h0000_0000;
    if (reg_wr && !write_protect && reg_addr == `FCG_OFF_CONFIG) begin
      next_cur.config_q = reg_wdata & `FCG_CONFIG_WMASK;
    end
    // Auto commit only in automatic mode; manual needs the command
    if (!manual_page_commit && buf_last_word_wr) begin
      next_cur.commit = 1'b1;
    end
    if (manual_page_commit && commit_cmd) begin
      next_cur.commit = 1'b1;
    end
    // Wake events first so a sleep entry in the same cycle wins
    if (cur.power_cut && sleep_exit && sleep_power_policy == `FCG_SP_WITH_CORE) begin
      next_cur.power_cut = 1'b0;
    end
    if (cur.power_cut && flash_access && sleep_power_policy == `FCG_SP_FIRST_TOUCH) begin
      next_cur.power_cut = 1'b0;
    end
    if (sleep_enter && (sleep_power_policy == `FCG_SP_FIRST_TOUCH ||
        sleep_power_policy == `FCG_SP_WITH_CORE)) begin
      next_cur.power_cut = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur.config_q <= `FCG_CONFIG_RESET;
      cur.power_cut <= 1'b0;
      cur.commit <= 1'b0;
      cur.rdata <= 32'h0000_0000;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign page_commit = cur.commit;
  assign power_cut_status = cur.power_cut;
endmodule

/* fcg_properties.sv */
`timescale 1ns/10ps
module fcg_properties(
  // Watched ports
  input wire logic clk, rst_b, reg_rd, reg_wr, rd_req, rd_ready, cache_active,
  input wire logic buf_last_word_wr, commit_cmd, page_commit, sleep_enter,
  input wire logic sleep_exit, flash_access, power_cut_status,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  geom_value_a: assert property (reg_rd && reg_addr == 8'h08 |=>
    reg_rdata == 32'h00060100) else $error("geometry");
  spare_zero_a: assert property (reg_rd && reg_addr == 8'h04 |=>
    (reg_rdata & 32'hFFF8FC61) == 32'h0) else $error("spare bit");
  idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("idle data");
  cache_bit_a: assert property (reg_rd && !reg_wr && reg_addr == 8'h04 |=>
    reg_rdata[18] != cache_active) else $error("cache");
  commit_cause_a: assert property (page_commit |->
    $past(buf_last_word_wr || commit_cmd)) else $error("commit");
  read_bound_a: assert property (rd_req |-> ##[0:16] rd_ready) else $error("read");
  cut_rise_a: assert property ($rose(power_cut_status) |-> $past(sleep_enter))
    else $error("cut");
  cut_fall_a: assert property ($fell(power_cut_status) |->
    $past(flash_access || sleep_exit)) else $error("wake");
  cover property (rd_req ##3 rd_ready);
  cover property (page_commit);
  cover property ($rose(power_cut_status));
endmodule
bind fcg_config fcg_properties u_props(.*);

/* fcg_fetcher.sv */
`timescale 1ns/10ps
module fcg_fetcher(
  // Read handshake
  input wire logic clk,
  input wire logic rd_ready,
  output logic rd_req,
  output logic rd_hit
);
  initial {rd_req, rd_hit} = 2'b0;
  // One-cycle request; hit line flips once released so a stale value is never trusted
  task automatic fetch(input logic h, output int n);
    n = 0;
    @(posedge clk) {rd_req, rd_hit} <= {1'b1, h};
    @(negedge clk);
    while (!rd_ready && n < 20) begin
      @(posedge clk) {rd_req, rd_hit} <= {1'b0, !h};
      @(negedge clk) n++;
    end
    if (n == 0) @(posedge clk) {rd_req, rd_hit} <= {1'b0, !h};
  endtask
endmodule

/* flash_ctrl_config_and_geometry_bench.sv */
`timescale 1ns/10ps
module flash_ctrl_config_and_geometry_bench;
  logic clk, rst_b, reg_wr, reg_rd, write_protect, rd_req, rd_hit, rd_ready, cache_active;
  logic buf_last_word_wr, commit_cmd, sleep_enter, sleep_exit, flash_access;
  logic page_commit, power_cut_status;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [4:0] ev;
  int err_total, cmp_count, n;
  // Config, cycles seen on a hit, cycles seen on a miss
  logic [31:0] rows [5][3] = '{'{32'h0, 32'h0, 32'h0}, '{32'h00010004, 32'h0, 32'h4},
    '{32'h0002000A, 32'h6, 32'h6}, '{32'h0001001E, 32'h0, 32'h10},
    '{32'hFFFFFFFF, 32'h10, 32'h10}};
  assign {buf_last_word_wr, commit_cmd, sleep_enter, sleep_exit, flash_access} = ev;
  fcg_config DUT(.*);
  fcg_fetcher u_cpu(.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    @(negedge clk) chk(reg_rdata, e);
  endtask
  task automatic pulse(input logic [4:0] b, input logic e);
    @(posedge clk) ev <= b;
    @(posedge clk) ev <= 5'h0;
    @(negedge clk) chk({31'h0, (b > 5'h4) ? page_commit : power_cut_status}, {31'h0, e});
  endtask
  initial begin
    {rst_b, reg_wr, reg_rd, write_protect, reg_addr, reg_wdata, ev} = '0;
    err_total = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h00060100);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h00060100);
    @(posedge clk) write_protect <= 1'b1;
    wr(8'h04, 32'h0000001E);
    rd(8'h04, 32'h0);
    @(posedge clk) write_protect <= 1'b0;
    foreach (rows[i]) begin
      wr(8'h04, rows[i][0]);
      rd(8'h04, rows[i][0] & 32'h0007039E);
      u_cpu.fetch(1'b1, n);
      chk(n, rows[i][1]);
      u_cpu.fetch(1'b0, n);
      chk(n, rows[i][2]);
    end
    for (int m = 0; m < 2; m++) begin
      wr(8'h04, m ? 32'h80 : 32'h0);
      pulse(5'h10, m == 0);
      pulse(5'h08, m == 1);
    end
    for (int p = 0; p < 4; p++) begin
      wr(8'h04, p << 8);
      pulse(5'h04, p < 2);
      pulse(5'h02, p == 0);
      pulse(5'h01, 1'b0);
    end
    end_of_test();
  end
endmodule
